// file: inc/queue_flag_consts.vh
// Overview of operation
// - Full flag driven only on write code match
// - Code width 1 to 3 bits, 256 queues
// - Full flag released when no local write queue
// - Local write switches keep driving, show new status
// - Ready flag updates with output register load
// - Fall-through: flag rises after last word read
// - New queue data and flag after 4 cycles
// - Old queue words shown until switch completes
// - Ready flag changes only on clock edges
// - Empty status kept for every queue
// - Only selected read queue drives ready flag
// - Empty flag driven only on read code match
// - Empty flag released when no local read queue
// - Local read switches keep driving, show new status
// - New full status shown by fourth write edge
`ifndef QUEUE_FLAG_CONSTS_VH
`define QUEUE_FLAG_CONSTS_VH
`define QADDR_WIDTH 8
`define MAX_QUEUES 256
`define LOCAL_QUEUES 32
`define LOCAL_QBITS 5
`define CODE_BITS_DEFAULT 3
`define WRITE_SWITCH_LATENCY 3
`define READ_SWITCH_LATENCY 4
`define LAT_CNT_WIDTH 3
`endif

// file: rtl/queue_status_flag_expansion.v
`timescale 1ns/10ps
`include "queue_flag_consts.vh"
// =====================================================
// Active queue full / output-ready flags with expansion
// =====================================================
module queue_status_flag_expansion
#(
  parameter CODE_BITS = `CODE_BITS_DEFAULT,
  parameter NQ = `LOCAL_QUEUES,
  parameter QB = `LOCAL_QBITS,
  parameter AW = `QADDR_WIDTH
)
(
  input wire CORE_CLK,
  input wire RESETN,
  input wire UNIT_CODE_BIT0,
  input wire UNIT_CODE_BIT1,
  input wire UNIT_CODE_BIT2,
  input wire FIRST_WORD_FALL_THROUGH,
  input wire [AW-1:0] WRITE_QUEUE_ADDR,
  input wire WRITE_ADDR_ENABLE,
  input wire [AW-1:0] READ_QUEUE_ADDR,
  input wire READ_ADDR_ENABLE,
  input wire READ_ENABLE_N,
  input wire [NQ-1:0] QUEUE_FULL,
  input wire [NQ-1:0] QUEUE_BECAME_NONEMPTY,
  input wire [NQ-1:0] QUEUE_DRAINED,
  input wire WORD_LOADED,
  output wire FULL_FLAG_N_O,
  output wire FULL_FLAG_N_OE,
  output wire EMPTY_FLAG_N_O,
  output wire EMPTY_FLAG_N_OE,
  output wire [QB-1:0] ACTIVE_READ_QUEUE,
  output wire [NQ-1:0] QUEUE_HAS_DATA
);
  // =====================================================
  // Reset synchroniser
  // =====================================================
  reg rst_meta;
  reg rst_n;
  always @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // =====================================================
  // Unit code capture
  // =====================================================
  // Straps are caught once after reset release and never again
  reg [2:0] unit_code;
  reg code_taken;
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unit_code <= 3'h0;
      code_taken <= 1'b0;
    end
    else if (!code_taken)
    begin
      unit_code <= {UNIT_CODE_BIT2, UNIT_CODE_BIT1, UNIT_CODE_BIT0};
      code_taken <= 1'b1;
    end
  end

  // Only the top CODE_BITS address bits name the unit; 256 queues max
  function code_match;
    input [AW-1:0] addr;
    input [2:0] code;
    integer k;
    reg m;
    begin
      m = 1'b1;
      for (k = 0; k < CODE_BITS; k = k + 1)
        if (addr[AW-1-k] != code[CODE_BITS-1-k])
          m = 1'b0;
      code_match = m;
    end
  endfunction

  // =====================================================
  // Write port: full flag
  // =====================================================
  localparam [`LAT_CNT_WIDTH-1:0] WR_LAT = `WRITE_SWITCH_LATENCY;
  localparam [`LAT_CNT_WIDTH-1:0] RD_LAT = `READ_SWITCH_LATENCY;
  localparam [`LAT_CNT_WIDTH-1:0] CNT_IDLE = {`LAT_CNT_WIDTH{1'b0}};
  localparam [`LAT_CNT_WIDTH-1:0] CNT_ONE =
    {{(`LAT_CNT_WIDTH-1){1'b0}}, 1'b1};
  reg write_mine;
  reg [QB-1:0] write_q;
  reg [`LAT_CNT_WIDTH-1:0] write_cnt;
  reg full_n;
  reg next_write_mine;
  reg [QB-1:0] next_write_q;
  reg [`LAT_CNT_WIDTH-1:0] next_write_cnt;
  reg next_full_n;
  wire write_sel = WRITE_ADDR_ENABLE;
  // The flag follows the queue only when no switch is half done, so a
  // stale status is never presented as that of the new queue
  wire write_settled = (write_cnt == CNT_IDLE) || (write_cnt == WR_LAT);

  always @*
  begin
    next_write_mine = write_mine;
    next_write_q = write_q;
    next_write_cnt = write_cnt;
    next_full_n = full_n;
    if (write_sel)
    begin
      // Match held until the next selection on this port
      next_write_mine = code_match(WRITE_QUEUE_ADDR, unit_code);
      next_write_q = WRITE_QUEUE_ADDR[QB-1:0];
      next_write_cnt = CNT_ONE;
    end
    else if (write_cnt == WR_LAT)
      next_write_cnt = CNT_IDLE;
    else if (write_cnt != CNT_IDLE)
      next_write_cnt = write_cnt + CNT_ONE;
    // New queue status lands by the fourth edge after selection
    if (write_settled)
      next_full_n = ~QUEUE_FULL[write_q];
  end

  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_mine <= 1'b0;
      write_q <= {QB{1'b0}};
      write_cnt <= CNT_IDLE;
      full_n <= 1'b1;
    end
    else
    begin
      write_mine <= next_write_mine;
      write_q <= next_write_q;
      write_cnt <= next_write_cnt;
      full_n <= next_full_n;
    end
  end
  // Released automatically; no user control of high impedance
  assign FULL_FLAG_N_OE = write_mine;
  assign FULL_FLAG_N_O = full_n;

  // =====================================================
  // Read port: empty / output-ready flag
  // =====================================================
  wire read_sel = READ_ADDR_ENABLE;
  wire [NQ-1:0] has_data;
  wire sel_has_data;
  wire cur_has_data;
  wire read_switching;
  wire read_landing;
  reg read_mine;
  reg [QB-1:0] read_q;
  reg [QB-1:0] pend_q;
  reg [`LAT_CNT_WIDTH-1:0] read_cnt;
  reg ready_n;
  reg next_read_mine;
  reg [QB-1:0] next_read_q;
  reg [QB-1:0] next_pend_q;
  reg [`LAT_CNT_WIDTH-1:0] next_read_cnt;
  reg next_ready_n;

  assign read_switching = (read_cnt != CNT_IDLE);
  // A fresh selection on the landing edge restarts the switch instead
  assign read_landing = (read_cnt == RD_LAT) && !read_sel;

  // Status kept for all queues, selected or not
  queue_status_ram #(.DEPTH(NQ), .ABITS(QB)) u_status
  (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .set_vec(QUEUE_BECAME_NONEMPTY),
    .clr_vec(QUEUE_DRAINED),
    .rd_addr(read_switching ? pend_q : read_q),
    .rd_bit(sel_has_data),
    .all_bits(has_data)
  );
  assign QUEUE_HAS_DATA = has_data;
  // Words still come from the old queue while a switch is pending
  assign cur_has_data = has_data[read_q];

  always @*
  begin
    next_read_mine = read_mine;
    next_read_q = read_q;
    next_pend_q = pend_q;
    next_read_cnt = read_cnt;
    next_ready_n = ready_n;
    if (read_sel)
    begin
      next_read_mine = code_match(READ_QUEUE_ADDR, unit_code);
      next_pend_q = READ_QUEUE_ADDR[QB-1:0];
      next_read_cnt = CNT_ONE;
    end
    else if (read_landing)
    begin
      next_read_q = pend_q;
      next_read_cnt = CNT_IDLE;
    end
    else if (read_switching)
      next_read_cnt = read_cnt + CNT_ONE;
    // The landing edge owns the flag; a load there belongs to the new queue
    if (read_landing)
      next_ready_n = ~sel_has_data;
    else if (WORD_LOADED)
      next_ready_n = ~cur_has_data;
    else if (FIRST_WORD_FALL_THROUGH && !READ_ENABLE_N && !cur_has_data)
      next_ready_n = 1'b1;
  end

  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      read_mine <= 1'b0;
      read_q <= {QB{1'b0}};
      pend_q <= {QB{1'b0}};
      read_cnt <= CNT_IDLE;
      ready_n <= 1'b1;
    end
    else
    begin
      read_mine <= next_read_mine;
      read_q <= next_read_q;
      pend_q <= next_pend_q;
      read_cnt <= next_read_cnt;
      ready_n <= next_ready_n;
    end
  end
  // Flag only drives when this unit owns the selected read queue
  assign EMPTY_FLAG_N_OE = read_mine;
  assign EMPTY_FLAG_N_O = ready_n;
  assign ACTIVE_READ_QUEUE = read_q;
endmodule // queue_status_flag_expansion

// file: rtl/queue_status_ram.v
`timescale 1ns/10ps
// Per-queue status bit store with registered read port
module queue_status_ram
#(
  parameter DEPTH = 32,
  parameter ABITS = 5
)
(
  input wire clk,
  input wire rst_n,
  input wire [DEPTH-1:0] set_vec,
  input wire [DEPTH-1:0] clr_vec,
  input wire [ABITS-1:0] rd_addr,
  output reg rd_bit,
  output wire [DEPTH-1:0] all_bits
);
  reg [DEPTH-1:0] bits;
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_bit
      // Set wins over clear so a concurrent event is not lost
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          bits[i] <= 1'b0;
        else if (set_vec[i])
          bits[i] <= 1'b1;
        else if (clr_vec[i])
          bits[i] <= 1'b0;
      end
    end
  endgenerate
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_bit <= 1'b0;
    else
      rd_bit <= bits[rd_addr];
  end
  assign all_bits = bits;
endmodule // queue_status_ram

// file: verif/qflag_sva.sv
`timescale 1ns/10ps
// ==========================================
// Flag drive, latency and status checks
module qflag_sva (
  input wire CORE_CLK,
  input wire RESETN,
  input wire UNIT_CODE_BIT0,
  input wire UNIT_CODE_BIT1,
  input wire UNIT_CODE_BIT2,
  input wire [7:0] WRITE_QUEUE_ADDR,
  input wire WRITE_ADDR_ENABLE,
  input wire [7:0] READ_QUEUE_ADDR,
  input wire READ_ADDR_ENABLE,
  input wire [31:0] QUEUE_FULL,
  input wire [31:0] QUEUE_BECAME_NONEMPTY,
  input wire [31:0] QUEUE_DRAINED,
  input wire FULL_FLAG_N_O,
  input wire FULL_FLAG_N_OE,
  input wire EMPTY_FLAG_N_OE,
  input wire [4:0] ACTIVE_READ_QUEUE,
  input wire [31:0] QUEUE_HAS_DATA
);
  wire [2:0] code = {UNIT_CODE_BIT2, UNIT_CODE_BIT1, UNIT_CODE_BIT0};
  wire wm = WRITE_QUEUE_ADDR[7:5] == code;
  wire rm = READ_QUEUE_ADDR[7:5] == code;
  reg [4:0] wq;
  reg [4:0] rq;
  always @(posedge CORE_CLK)
  begin
    if (WRITE_ADDR_ENABLE) wq <= WRITE_QUEUE_ADDR[4:0];
    if (READ_ADDR_ENABLE) rq <= READ_QUEUE_ADDR[4:0];
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  sequence s_wsel; WRITE_ADDR_ENABLE ##1 !WRITE_ADDR_ENABLE; endsequence
  sequence s_rsel; READ_ADDR_ENABLE ##1 !READ_ADDR_ENABLE; endsequence
  property p_wr_oe; s_wsel |-> ##1 FULL_FLAG_N_OE == $past(wm, 2); endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("full drive wrong");
  property p_rd_oe; s_rsel |-> ##1 EMPTY_FLAG_N_OE == $past(rm, 2); endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("empty drive wrong");
  property p_full;
    s_wsel ##0 !WRITE_ADDR_ENABLE [*3]
      |-> ##1 FULL_FLAG_N_O == !$past(QUEUE_FULL[wq]);
  endproperty
  a_full: assert property (p_full) else $error("full status late");
  property p_rq;
    s_rsel ##0 !READ_ADDR_ENABLE [*4] |-> ##1 ACTIVE_READ_QUEUE == rq;
  endproperty
  a_rq: assert property (p_rq) else $error("read queue late");
  property p_r_old;
    s_rsel ##0 !READ_ADDR_ENABLE [*3] |-> ##1 $stable(ACTIVE_READ_QUEUE);
  endproperty
  a_r_old: assert property (p_r_old) else $error("read queue early");
  property p_w_hold;
    !WRITE_ADDR_ENABLE [*2] |=> $stable(FULL_FLAG_N_OE);
  endproperty
  a_w_hold: assert property (p_w_hold) else $error("full drive moved");
  property p_r_hold;
    !READ_ADDR_ENABLE [*2] |=> $stable(EMPTY_FLAG_N_OE);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("empty drive moved");
  property p_set;
    |QUEUE_BECAME_NONEMPTY |=> (QUEUE_HAS_DATA
      & $past(QUEUE_BECAME_NONEMPTY)) == $past(QUEUE_BECAME_NONEMPTY);
  endproperty
  a_set: assert property (p_set) else $error("status not set");
  property p_clr;
    (|QUEUE_DRAINED && !(|QUEUE_BECAME_NONEMPTY))
      |=> (QUEUE_HAS_DATA & $past(QUEUE_DRAINED)) == 32'h0000_0000;
  endproperty
  a_clr: assert property (p_clr) else $error("status not cleared");
endmodule // qflag_sva
bind queue_status_flag_expansion qflag_sva u_sva (.*);

// file: verif/queue_side_model.sv
`timescale 1ns/10ps
// ==========================================
// Queue storage side: fills and drains queues
module queue_side_model (
  input wire clk,
  input wire fill,
  input wire drain,
  input wire [4:0] q,
  output reg [31:0] full,
  output reg [31:0] nonempty,
  output reg [31:0] drained
);
  initial full = 32'h0000_0000;
  always @(posedge clk)
  begin
    // One-cycle pulses, so a queue is never set and cleared at once
    nonempty <= fill ? 32'h0000_0001 << q : 32'h0000_0000;
    drained <= drain ? 32'h0000_0001 << q : 32'h0000_0000;
    if (fill) full[q] <= 1'b1;
    if (drain) full[q] <= 1'b0;
  end
endmodule // queue_side_model

// file: verif/testbench.sv
`timescale 1ns/10ps
// ==========================================
// Self-checking bench, unit code 3'b101
`define CHK(a,b,m) begin num_checks = num_checks + 1; \
  if ((a) !== (b)) begin n_fail = n_fail + 1; \
  $display("[ERR] %0t %s", $time, m); end end
module testbench;
  reg clk, rst_n, wen, ren, fill, drain;
  reg ld, rdn, first_word_fall_through;
  reg [7:0] wa, ra;
  reg [4:0] fq;
  wire [31:0] full, ne, dr, has;
  wire ff, ffoe, ef, efoe;
  wire [4:0] arq;
  integer n_fail, num_checks;
  queue_side_model u_side (.clk(clk), .fill(fill), .drain(drain), .q(fq),
    .full(full), .nonempty(ne), .drained(dr));
  queue_status_flag_expansion u_dut (.CORE_CLK(clk), .RESETN(rst_n),
    .UNIT_CODE_BIT0(1'b1), .UNIT_CODE_BIT1(1'b0), .UNIT_CODE_BIT2(1'b1),
    .FIRST_WORD_FALL_THROUGH(first_word_fall_through), .WRITE_QUEUE_ADDR(wa),
    .WRITE_ADDR_ENABLE(wen), .READ_QUEUE_ADDR(ra), .READ_ADDR_ENABLE(ren),
    .READ_ENABLE_N(rdn), .QUEUE_FULL(full), .QUEUE_BECAME_NONEMPTY(ne),
    .QUEUE_DRAINED(dr), .WORD_LOADED(ld), .FULL_FLAG_N_O(ff),
    .FULL_FLAG_N_OE(ffoe), .EMPTY_FLAG_N_O(ef), .EMPTY_FLAG_N_OE(efoe),
    .ACTIVE_READ_QUEUE(arq), .QUEUE_HAS_DATA(has));
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // Selection held for exactly one sampling edge
  task sel(input w, input [7:0] a);
  begin
    @(posedge clk) #1;
    if (w) {wen, wa} = {1'b1, a}; else {ren, ra} = {1'b1, a};
    @(posedge clk) #1;
    wen = 0;
    ren = 0;
  end
  endtask
  task pulse(input f, input d, input [4:0] q);
  begin
    @(posedge clk) #1;
    {fill, drain, fq} = {f, d, q};
    @(posedge clk) #1;
    {fill, drain} = 2'b00;
    repeat (2) @(posedge clk);
    #1;
  end
  endtask
  task t_write;
  begin
    pulse(1, 0, 5'h03);
    sel(1, 8'hA3);
    repeat (4) @(posedge clk);
    #2;
    `CHK(ffoe, 1'b1, "full not driven")
    `CHK(ff, 1'b0, "full status wrong")
    sel(1, 8'hA4);
    repeat (4) @(posedge clk);
    #2;
    `CHK({ffoe, ff}, 2'b11, "local switch wrong")
    sel(1, 8'h63);
    repeat (2) @(posedge clk);
    #2;
    `CHK(ffoe, 1'b0, "full not released")
    $display("t_write done");
  end
  endtask
  task t_read;
  begin
    pulse(1, 0, 5'h07);
    sel(0, 8'hA7);
    repeat (5) @(posedge clk);
    #2;
    `CHK({efoe, arq}, 6'h27, "read select wrong")
    `CHK(ef, 1'b0, "new queue data not shown")
    sel(0, 8'hB2);
    `CHK(arq, 5'h07, "old queue dropped early")
    `CHK(ef, 1'b0, "old queue flag dropped early")
    repeat (5) @(posedge clk);
    #2;
    `CHK({efoe, arq}, 6'h32, "local read switch wrong")
    `CHK(ef, 1'b1, "new empty queue not shown")
    sel(0, 8'h27);
    repeat (2) @(posedge clk);
    #2;
    `CHK(efoe, 1'b0, "empty not released")
    $display("t_read done");
  end
  endtask
  task t_ready;
  begin
    pulse(0, 1, 5'h07);
    `CHK(ef, 1'b0, "flag moved without a read")
    @(posedge clk) #1;
    rdn = 0;
    @(posedge clk) #1;
    rdn = 1;
    `CHK(ef, 1'b1, "fall-through flag not raised")
    pulse(1, 0, 5'h07);
    `CHK(ef, 1'b1, "flag changed without a load")
    @(posedge clk) #1;
    ld = 1;
    @(posedge clk) #1;
    ld = 0;
    `CHK(ef, 1'b0, "load did not show ready")
    first_word_fall_through = 0;
    pulse(0, 1, 5'h07);
    @(posedge clk) #1;
    rdn = 0;
    @(posedge clk) #1;
    rdn = 1;
    `CHK(ef, 1'b0, "flag rose outside fall-through")
    first_word_fall_through = 1;
    $display("t_ready done");
  end
  endtask
  task t_status;
  begin
    pulse(1, 0, 5'h09);
    `CHK(has[9], 1'b1, "unselected queue not set")
    pulse(0, 1, 5'h09);
    `CHK(has[9], 1'b0, "queue not cleared")
    $display("t_status done");
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  initial
  begin
    {n_fail, num_checks} = 0;
    {rst_n, wen, ren, fill, drain, wa, ra, fq} = 0;
    ld = 0;
    rdn = 1;
    first_word_fall_through = 1;
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    repeat (6) @(posedge clk);
    t_write;
    t_read;
    t_ready;
    t_status;
    give_verdict;
  end
  // Tests need under a hundred cycles; the limit allows 5000
  initial
  begin
    #100000;
    n_fail = n_fail + 1;
    give_verdict;
  end
endmodule // testbench
